// File: soc_cfg_regs.svh
/*
 * Constants for the serial output-enable loader: field positions, reset values,
 * controller register offsets and strobe timing.
 * Assumes it is included by bare name wherever the constants are needed.
 */
`ifndef SOC_CFG_REGS_SVH
`define SOC_CFG_REGS_SVH

// configuration word layout
`define SOC_NUM_PAIRS 10
`define SOC_CFG_BITS 11
`define SOC_SEL_BIT 10
`define SOC_CFG_RESET 11'h000

// synchronised pin positions in the device
`define SOC_PIN_STB 0
`define SOC_PIN_SER 1
`define SOC_PIN_PRG 2
`define SOC_PIN_S0T 3
`define SOC_PIN_S0C 4
`define SOC_PIN_S1T 5
`define SOC_PIN_S1C 6
`define SOC_NUM_PINS 7

// controller registers, byte offsets
`define SOC_REG_WORD 4'h0
`define SOC_REG_CMD 4'h4
`define SOC_REG_STATUS 4'h8
`define SOC_CMD_START 0
`define SOC_CMD_STD 1
`define SOC_CMD_STD_SEL 2
`define SOC_ST_BUSY 0
`define SOC_ST_LOADED 1

// strobe half period; 40 ns keeps each strobe phase above its three-cycle (30 ns) minimum
`define SOC_CLK_NS 10
`define SOC_STB_HALF_NS 40
`define SOC_STB_HALF_CYC (`SOC_STB_HALF_NS / `SOC_CLK_NS)

`endif

// File: soc_cfg_pkg.sv
/*
 * Types shared by both ends of the serial output-enable loader.
 * Assumes soc_cfg_regs.svh supplies the numeric constants.
 */
package soc_cfg_pkg;

   // device loader state
   typedef enum logic [0:0] {
      SOC_DEV_SHIFT = 1'b0,
      SOC_DEV_LOCKED = 1'b1
   } soc_dev_state_type;

   // controller sequencer state
   typedef enum logic [2:0] {
      SOC_CTL_IDLE = 3'b000,
      SOC_CTL_RESET = 3'b001,
      SOC_CTL_SHIFT = 3'b010,
      SOC_CTL_LOAD = 3'b011,
      SOC_CTL_DONE = 3'b100
   } soc_ctl_state_type;

endpackage : soc_cfg_pkg

// File: soc_cfg_if.sv
/*
 * Three-wire configuration link between controller and fan-out device.
 * Assumes the controller drives all three wires; the device only listens.
 */
`timescale 1ns/1ns
interface soc_cfg_if;
   logic config_shift_strobe;
   logic serial_data;
   logic program_mode;

   modport dev (
      input config_shift_strobe,
      input serial_data,
      input program_mode
   );

   modport ctl (
      output config_shift_strobe,
      output serial_data,
      output program_mode
   );
endinterface : soc_cfg_if

// File: soc_cfg_dev.sv
/*
 * Fan-out device end: eleven-stage shift register, control register, one-load
 * lock and the output-pair selection of input_source_zero / input_source_one.
 * Assumes every link and source pin is asynchronous to i_clk and that the
 * strobe stays high and low for at least three i_clk cycles each.
 * Source clocks are modelled at the sampled rate of i_clk.
 */
// Contract
// - eleven-stage shift register plus control register
// - programmed mode: shift serial level in
// - eleven shift strobes, then one load strobe
// - bit 0 enables pair 9, downward
// - bit 10 selects input source
// - disabled pair off; enabled follows selected source
// - strobe with program low resets everything
// - one load per reset, then locked
// - program low: all pairs enabled
// - program low: serial pin selects source
`timescale 1ns/1ns
`include "soc_cfg_regs.svh"
module soc_cfg_dev
   import soc_cfg_pkg::*;
#(
   parameter int NUM_PAIRS = `SOC_NUM_PAIRS
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   soc_cfg_if.dev link,
   input wire logic i_src0_true,
   input wire logic i_src0_comp,
   input wire logic i_src1_true,
   input wire logic i_src1_comp,
   output logic [NUM_PAIRS-1:0] o_pair_true,
   output logic [NUM_PAIRS-1:0] o_pair_comp,
   output logic [NUM_PAIRS-1:0] o_pair_off,
   output logic o_loaded
);

   // width of the serial word: ten enables plus the source select
   localparam int CW = `SOC_CFG_BITS;

   // first bit shifted in lands in the last stage; flip to bit-number order
   function automatic logic [CW-1:0] stage_to_bits(input logic [CW-1:0] stages);
      logic [CW-1:0] bits;
      bits = '0;
      for (int n = 0; n < CW; n++) begin
         bits[n] = stages[CW-1-n];
      end
      return bits;
   endfunction : stage_to_bits

   // raw pins and their synchronised copies; only the sync stage reads the meta stage
   logic [`SOC_NUM_PINS-1:0] pin_raw;
   logic [`SOC_NUM_PINS-1:0] pin_meta_reg;
   logic [`SOC_NUM_PINS-1:0] pin_sync_reg;
   logic strobe_prev_reg;
   wire strobe_rise;
   wire prog_sync;
   wire serial_sync;

   // loader state; the count runs 0 to 11, the twelfth edge loads
   soc_dev_state_type state_reg;
   soc_dev_state_type state_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic [CW-1:0] shift_reg;
   logic [CW-1:0] shift_next;
   logic [CW-1:0] ctrl_reg;
   logic [CW-1:0] ctrl_next;
   logic loaded_reg;
   logic loaded_next;

   // output path; pair drivers are flops so a select change cannot glitch
   wire sel_src;
   wire src_true;
   wire src_comp;
   wire src_high;
   wire [NUM_PAIRS-1:0] pair_en;
   logic [NUM_PAIRS-1:0] true_reg;
   logic [NUM_PAIRS-1:0] comp_reg;
   logic [NUM_PAIRS-1:0] off_reg;

   // pins gathered so one loop synchronises all of them
   assign pin_raw[`SOC_PIN_STB] = link.config_shift_strobe;
   assign pin_raw[`SOC_PIN_SER] = link.serial_data;
   assign pin_raw[`SOC_PIN_PRG] = link.program_mode;
   assign pin_raw[`SOC_PIN_S0T] = i_src0_true;
   assign pin_raw[`SOC_PIN_S0C] = i_src0_comp;
   assign pin_raw[`SOC_PIN_S1T] = i_src1_true;
   assign pin_raw[`SOC_PIN_S1C] = i_src1_comp;

   // two-flop synchronisers; the meta stage feeds only the sync stage
   generate
      for (genvar g = 0; g < `SOC_NUM_PINS; g++) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               pin_meta_reg[g] <= 1'b0;
               pin_sync_reg[g] <= 1'b0;
            end else begin
               pin_meta_reg[g] <= pin_raw[g];
               pin_sync_reg[g] <= pin_meta_reg[g];
            end
         end
      end
   endgenerate

   // strobe edge; serial and program share the strobe's latency, so setup holds
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         strobe_prev_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= pin_sync_reg[`SOC_PIN_STB];
      end
   end

   assign strobe_rise = pin_sync_reg[`SOC_PIN_STB] & ~strobe_prev_reg;
   assign prog_sync = pin_sync_reg[`SOC_PIN_PRG];
   assign serial_sync = pin_sync_reg[`SOC_PIN_SER];

   // loader sequence on each strobe edge
   // only the synchronised rising edge acts, so a long high phase
   // counts once and never shifts twice
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      shift_next = shift_reg;
      ctrl_next = ctrl_reg;
      loaded_next = loaded_reg;
      if (strobe_rise) begin
         if (!prog_sync) begin
            // reset strobe wins; pairs stay all enabled while program is low
            state_next = SOC_DEV_SHIFT;
            count_next = 4'h0;
            shift_next = `SOC_CFG_RESET;
            ctrl_next = `SOC_CFG_RESET;
            loaded_next = 1'b0;
         end else begin
            unique case (state_reg)
               SOC_DEV_SHIFT: begin
                  if (count_reg == 4'(CW)) begin
                     ctrl_next = stage_to_bits(shift_reg);
                     state_next = SOC_DEV_LOCKED;
                     loaded_next = 1'b1;
                  end else begin
                     shift_next = {shift_reg[CW-2:0], serial_sync};
                     count_next = count_reg + 4'h1;
                  end
               end
               SOC_DEV_LOCKED: begin
                  // further strobes ignored until a reset strobe
                  // the shift register is frozen too, so stray strobes leave no trace
                  state_next = SOC_DEV_LOCKED;
               end
            endcase
         end
      end
   end

   // loader registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg <= SOC_DEV_SHIFT;
         count_reg <= 4'h0;
         shift_reg <= `SOC_CFG_RESET;
         ctrl_reg <= `SOC_CFG_RESET;
         loaded_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         shift_reg <= shift_next;
         ctrl_reg <= ctrl_next;
         loaded_reg <= loaded_next;
      end
   end

   // source select: control bit in programmed mode, serial pin otherwise
   assign sel_src = prog_sync ? ctrl_reg[`SOC_SEL_BIT] : serial_sync;
   // sources are sampled by i_clk, so one above half its rate aliases
   assign src_true = sel_src ? pin_sync_reg[`SOC_PIN_S1T] : pin_sync_reg[`SOC_PIN_S0T];
   assign src_comp = sel_src ? pin_sync_reg[`SOC_PIN_S1C] : pin_sync_reg[`SOC_PIN_S0C];
   // equal levels (open or shorted input) read as low, the failsafe state
   assign src_high = src_true & ~src_comp;

   // per-pair enable and registered drivers
   // a disabled pair drives both lines low; a real driver would float them
   generate
      for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
         assign pair_en[p] = prog_sync ? ctrl_reg[NUM_PAIRS-1-p] : 1'b1;
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               true_reg[p] <= 1'b0;
               comp_reg[p] <= 1'b0;
               off_reg[p] <= 1'b1;
            end else begin
               true_reg[p] <= pair_en[p] & src_high;
               comp_reg[p] <= pair_en[p] & ~src_high;
               off_reg[p] <= ~pair_en[p];
            end
         end
      end
   endgenerate

   // registered results to the ports
   assign o_pair_true = true_reg;
   assign o_pair_comp = comp_reg;
   assign o_pair_off = off_reg;
   assign o_loaded = loaded_reg;

endmodule : soc_cfg_dev

// File: soc_cfg_ctl.sv
/*
 * Controller end: software registers and the strobe sequencer that resets the
 * device, shifts eleven bits and gives the load strobe.
 * Assumes a plain register port with one-cycle strobes and reads answered
 * one cycle later.
 */
`timescale 1ns/1ns
`include "soc_cfg_regs.svh"
module soc_cfg_ctl
   import soc_cfg_pkg::*;
#(
   parameter int HALF_CYC = `SOC_STB_HALF_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   soc_cfg_if.ctl link
);

   localparam int CW = `SOC_CFG_BITS;

   // word layout bit p enables pair p; serial bit n carries pair 9-n
   function automatic logic serial_bit(input logic [CW-1:0] word, input logic [3:0] n);
      logic b;
      b = 1'b0;
      if (n == 4'(`SOC_SEL_BIT)) begin
         b = word[`SOC_SEL_BIT];
      end else begin
         b = word[4'(`SOC_NUM_PAIRS - 1) - n];
      end
      return b;
   endfunction : serial_bit

   soc_ctl_state_type state_reg;
   logic [CW-1:0] word_reg;
   logic std_reg;
   logic std_sel_reg;
   logic loaded_reg;
   logic [3:0] idx_reg;
   logic [7:0] div_reg;
   logic strobe_reg;
   logic prog_reg;
   logic serial_reg;
   logic [31:0] rdata_reg;
   wire tick;
   wire busy;
   wire wr_word;
   wire wr_cmd;

   // register decode
   assign wr_word = i_wr & (i_addr == `SOC_REG_WORD);
   assign wr_cmd = i_wr & (i_addr == `SOC_REG_CMD);
   assign busy = (state_reg != SOC_CTL_IDLE) & (state_reg != SOC_CTL_DONE);
   assign tick = (div_reg == 8'(HALF_CYC - 1));

   // software registers and read port, unmapped reads give zero
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         word_reg <= `SOC_CFG_RESET;
         std_reg <= 1'b1;
         std_sel_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (wr_word) begin
            word_reg <= i_wdata[CW-1:0];
         end
         if (wr_cmd) begin
            std_reg <= i_wdata[`SOC_CMD_STD];
            std_sel_reg <= i_wdata[`SOC_CMD_STD_SEL];
         end
         rdata_reg <= 32'h0000_0000;
         if (i_rd && i_addr == `SOC_REG_WORD) begin
            rdata_reg <= {21'h00_0000, word_reg};
         end else if (i_rd && i_addr == `SOC_REG_CMD) begin
            rdata_reg <= {29'h0000_0000, std_sel_reg, std_reg, 1'b0};
         end else if (i_rd && i_addr == `SOC_REG_STATUS) begin
            rdata_reg <= {30'h0000_0000, loaded_reg, busy};
         end
      end
   end

   // strobe divider runs only while a sequence is active
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !busy || tick) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // sequencer: reset strobe, eleven shift strobes, one load strobe
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg <= SOC_CTL_IDLE;
         idx_reg <= 4'h0;
         strobe_reg <= 1'b0;
         prog_reg <= 1'b0;
         serial_reg <= 1'b0;
         loaded_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            SOC_CTL_IDLE, SOC_CTL_DONE: begin
               if (wr_cmd && i_wdata[`SOC_CMD_START]) begin
                  state_reg <= SOC_CTL_RESET;
                  prog_reg <= 1'b0;
                  serial_reg <= 1'b0;
                  loaded_reg <= 1'b0;
               end else if (std_reg) begin // standard mode may follow a finished load
                  prog_reg <= 1'b0;
                  serial_reg <= std_sel_reg;
               end
            end
            SOC_CTL_RESET: begin
               if (tick && !strobe_reg) begin
                  strobe_reg <= 1'b1;
               end else if (tick) begin
                  strobe_reg <= 1'b0;
                  state_reg <= SOC_CTL_SHIFT;
                  prog_reg <= 1'b1;
                  idx_reg <= 4'h0;
                  serial_reg <= serial_bit(word_reg, 4'h0);
               end
            end
            SOC_CTL_SHIFT: begin
               if (tick && !strobe_reg) begin
                  strobe_reg <= 1'b1;
               end else if (tick) begin
                  strobe_reg <= 1'b0;
                  if (idx_reg == 4'(CW - 1)) begin
                     state_reg <= SOC_CTL_LOAD;
                  end else begin
                     idx_reg <= idx_reg + 4'h1;
                     serial_reg <= serial_bit(word_reg, idx_reg + 4'h1);
                  end
               end
            end
            SOC_CTL_LOAD: begin
               if (tick && !strobe_reg) begin
                  strobe_reg <= 1'b1;
               end else if (tick) begin
                  strobe_reg <= 1'b0;
                  state_reg <= SOC_CTL_DONE;
                  loaded_reg <= 1'b1;
               end
            end
            default: begin
               state_reg <= SOC_CTL_IDLE;
            end
         endcase
      end
   end

   assign link.config_shift_strobe = strobe_reg;
   assign link.program_mode = prog_reg;
   assign link.serial_data = serial_reg;
   assign o_rdata = rdata_reg;

endmodule : soc_cfg_ctl

// File: soc_cfg_assertions.sv
/*
 * Checker for the three-wire configuration link and the device flags.
 * Assumes the testbench instantiates it beside the link interface, one clock.
 */
`timescale 1ns/1ns
module soc_cfg_assertions (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic config_shift_strobe,
   input wire logic serial_data,
   input wire logic program_mode,
   input wire logic [9:0] o_pair_off,
   input wire logic o_loaded
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   logic strobe_reg;
   logic [3:0] rise_cnt_reg;
   logic [3:0] std_cnt_reg;
   logic [3:0] rise_cnt_next;
   logic [3:0] std_cnt_next;
   wire strobe_rise = config_shift_strobe & ~strobe_reg;

   // counters saturate at 15 so a runaway strobe train cannot wrap past 12
   assign rise_cnt_next = !program_mode ? 4'h0 :
                          (strobe_rise && rise_cnt_reg != 4'hf) ? rise_cnt_reg + 4'h1 :
                          rise_cnt_reg;
   assign std_cnt_next = program_mode ? 4'h0 :
                         (std_cnt_reg == 4'hf) ? std_cnt_reg : std_cnt_reg + 4'h1;

   // strobe edge and mode counters
   always_ff @(posedge i_clk) begin
      strobe_reg <= i_sys_rst ? 1'b0 : config_shift_strobe;
      rise_cnt_reg <= i_sys_rst ? 4'h0 : rise_cnt_next;
      std_cnt_reg <= i_sys_rst ? 4'h0 : std_cnt_next;
   end

   strobe_high_a: assert property ($rose(config_shift_strobe) |-> config_shift_strobe[*3])
      else $error("strobe high phase too short");
   strobe_low_a: assert property ($fell(config_shift_strobe) |-> !config_shift_strobe[*3])
      else $error("strobe low phase too short");
   data_hold_a: assert property (config_shift_strobe && strobe_reg |->
      $stable(serial_data) && $stable(program_mode)) else $error("link changed while strobe high");
   data_setup_a: assert property (strobe_rise |->
      $stable(serial_data) && $stable(program_mode)) else $error("link changed at strobe rise");
   reset_first_a: assert property ($rose(program_mode) |-> $fell(config_shift_strobe))
      else $error("programmed mode entered without a reset strobe");
   reset_clears_a: assert property (strobe_rise && !program_mode |-> ##[1:6] !o_loaded)
      else $error("reset strobe did not clear loaded flag");
   all_enabled_a: assert property (std_cnt_reg >= 4'h8 |-> o_pair_off == 10'h000)
      else $error("pair disabled in standard mode");
   load_count_a: assert property ($rose(o_loaded) |-> rise_cnt_reg == 4'hc)
      else $error("load not on twelfth strobe");
   count_limit_a: assert property (rise_cnt_reg <= 4'hc)
      else $error("more than twelve programmed strobes");
endmodule : soc_cfg_assertions

// File: test_serial_output_enable_config.sv
/*
 * Self-checking testbench: controller and device joined by the link.
 * Assumes the package, header, interface and both ends are compiled first.
 */
`timescale 1ns/1ns
`include "soc_cfg_regs.svh"
module test_serial_output_enable_config;
   import soc_cfg_pkg::*;
   logic i_clk;
   logic i_sys_rst;
   logic [3:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [31:0] o_rdata;
   logic s0t, s0c, s1t, s1c;
   logic [9:0] o_pair_true, o_pair_comp, o_pair_off;
   logic o_loaded;
   logic strobe_prev;
   logic seen_q[$];
   int num_errors;
   int n_compared;

   soc_cfg_if u_soc_cfg_if ();
   soc_cfg_ctl u_soc_cfg_ctl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(u_soc_cfg_if.ctl));
   soc_cfg_dev u_soc_cfg_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_soc_cfg_if.dev),
      .i_src0_true(s0t), .i_src0_comp(s0c), .i_src1_true(s1t), .i_src1_comp(s1c),
      .o_pair_true(o_pair_true), .o_pair_comp(o_pair_comp), .o_pair_off(o_pair_off),
      .o_loaded(o_loaded));
   soc_cfg_assertions u_soc_cfg_assertions (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .config_shift_strobe(u_soc_cfg_if.config_shift_strobe),
      .serial_data(u_soc_cfg_if.serial_data), .program_mode(u_soc_cfg_if.program_mode),
      .o_pair_off(o_pair_off), .o_loaded(o_loaded));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // capture each serial bit at a programmed strobe rise, straight off the wire
   always @(posedge i_clk) begin
      strobe_prev <= u_soc_cfg_if.config_shift_strobe;
      if (u_soc_cfg_if.config_shift_strobe && !strobe_prev && u_soc_cfg_if.program_mode) begin
         seen_q.push_back(u_soc_cfg_if.serial_data);
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd

   task automatic set_src(input logic [1:0] a, input logic [1:0] b);
      @(posedge i_clk);
      s0t <= a[1];
      s0c <= a[0];
      s1t <= b[1];
      s1c <= b[0];
   endtask : set_src

   // pins pass a two-flop sync plus output flop, so eight cycles is ample
   task automatic check_pairs(input logic [9:0] en, input logic v);
      logic [9:0] e_true;
      logic [9:0] e_comp;
      e_true = en & {10{v}};
      e_comp = en & {10{~v}};
      repeat (8) @(posedge i_clk);
      #1;
      chk("pair_off", {22'h0, ~en}, {22'h0, o_pair_off});
      chk("pair_true", {22'h0, e_true}, {22'h0, o_pair_true});
      chk("pair_comp", {22'h0, e_comp}, {22'h0, o_pair_comp});
   endtask : check_pairs

   task automatic t_standard();
      logic [1:0] lv [3];
      logic v;
      lv = '{2'b10, 2'b01, 2'b00};
      for (int s = 0; s < 2; s++) begin
         wr(`SOC_REG_CMD, {29'h0, s[0], 2'b10});
         for (int k = 0; k < 3; k++) begin
            v = lv[k][1] & ~lv[k][0];
            if (s == 0) set_src(lv[k], {~v, v});
            else set_src({~v, v}, lv[k]);
            check_pairs(10'h3ff, v);
         end
      end
      $display("test standard done");
   endtask : t_standard

   task automatic t_program(input logic [10:0] w);
      logic [31:0] d;
      int n;
      seen_q.delete();
      set_src(2'b10, 2'b01);
      wr(`SOC_REG_WORD, {21'h0, w});
      wr(`SOC_REG_CMD, 32'h1);
      rd(`SOC_REG_STATUS, d);
      chk("busy", 32'h1, {31'h0, d[`SOC_ST_BUSY]});
      n = 0;
      // poll status under a bound; a full load takes about 104 cycles
      do begin
         rd(`SOC_REG_STATUS, d);
         n++;
      end while (!(d[`SOC_ST_BUSY] === 1'b0 && d[`SOC_ST_LOADED] === 1'b1) && n < 200);
      chk("status", 32'h2, d);
      chk("loaded", 32'h1, {31'h0, o_loaded});
      chk("strobes", 32'd12, 32'(seen_q.size()));
      for (int b = 0; b < 11; b++) begin
         chk("serial bit", {31'h0, (b < 10) ? w[9 - b] : w[10]}, {31'h0, seen_q[b]});
      end
      check_pairs(w[9:0], ~w[10]);
      set_src(2'b01, 2'b10);
      check_pairs(w[9:0], w[10]);
      $display("test program %h done", w);
   endtask : t_program

   task automatic t_regs();
      logic [31:0] d;
      rd(4'hc, d);
      chk("unmapped read", 32'h0, d);
      wr(4'hc, 32'hffffffff);
      rd(`SOC_REG_STATUS, d);
      chk("status after stray write", 32'h2, d);
      $display("test registers done");
   endtask : t_regs

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // run needs a few hundred cycles; 30000 means a hang
   initial begin
      #300000;
      num_errors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      conclude();
   end

   initial begin
      i_sys_rst = 1'b1;
      i_addr = 4'h0;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      {s0t, s0c, s1t, s1c} = 4'h0;
      num_errors = 0;
      n_compared = 0;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_standard();
      t_program(11'h4b1);
      t_program(11'h30e);
      t_regs();
      t_standard();
      conclude();
   end
endmodule : test_serial_output_enable_config
